// *** pkg/period_timer_pkg.sv ***
package period_timer_pkg;

    // ==========================================
    // register map and field layout
    // ==========================================
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned SRC_W = 8;
    localparam int unsigned SRC_SEL_W = 3;
    localparam int unsigned PRESC_SEL_W = 3;
    localparam int unsigned PRESC_CNT_W = 7;
    localparam int unsigned POST_W = 4;
    localparam int unsigned MODE_W = 5;

    localparam logic [ADDR_W-1:0] OFS_COUNT = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_HW_LIMIT = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_RESET_SRC = 3'h4;

    localparam int unsigned CTRL_RUN_BIT = 7;
    localparam int unsigned CTRL_PRESC_LSB = 4;
    localparam int unsigned CTRL_POST_LSB = 0;
    localparam int unsigned MODE_CLASS_LSB = 3;

    localparam logic [DATA_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] PERIOD_RESET = 8'hff;
    localparam logic [PRESC_SEL_W-1:0] PRESC_SEL_RESET = 3'h0;
    localparam logic [POST_W-1:0] POST_SEL_RESET = 4'h0;
    localparam logic [MODE_W-1:0] MODE_RESET = 5'h00;
    localparam logic [SRC_SEL_W-1:0] SRC_SEL_RESET = 3'h0;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

    // ==========================================
    // mode classes and low mode codes
    // ==========================================
    localparam logic [1:0] CLASS_FREE = 2'h0;
    localparam logic [1:0] CLASS_ONESHOT = 2'h1;
    localparam logic [1:0] CLASS_MONO = 2'h2;
    localparam logic [2:0] LOW_SW = 3'h0;
    localparam logic [2:0] LOW_1 = 3'h1;
    localparam logic [2:0] LOW_2 = 3'h2;
    localparam logic [2:0] LOW_3 = 3'h3;
    localparam logic [2:0] LOW_4 = 3'h4;
    localparam logic [2:0] LOW_5 = 3'h5;
    localparam logic [2:0] LOW_6 = 3'h6;
    localparam logic [2:0] LOW_7 = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN = 2'h1,
        ST_STOP = 2'h3
    } run_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] count;
        logic [DATA_W-1:0] period;
        logic run_enable_bit;
        logic [PRESC_SEL_W-1:0] presc_sel;
        logic [POST_W-1:0] postscale_select;
        logic [MODE_W-1:0] mode;
        logic [SRC_SEL_W-1:0] src_sel;
        logic [PRESC_CNT_W-1:0] presc_cnt;
        logic [POST_W-1:0] post_cnt;
        run_state_e state;
        logic [SRC_W-1:0] sync1;
        logic [SRC_W-1:0] sync2;
        logic ers_prev;
        logic pulse;
        logic [DATA_W-1:0] rdata;
    } timer_state_s;

    localparam timer_state_s TIMER_STATE_RESET = '{
        count: COUNT_RESET,
        period: PERIOD_RESET,
        run_enable_bit: 1'b0,
        presc_sel: PRESC_SEL_RESET,
        postscale_select: POST_SEL_RESET,
        mode: MODE_RESET,
        src_sel: SRC_SEL_RESET,
        presc_cnt: '0,
        post_cnt: '0,
        state: ST_IDLE,
        sync1: '0,
        sync2: '0,
        ers_prev: 1'b0,
        pulse: 1'b0,
        rdata: READ_IDLE
    };

endpackage

// *** verilog/period_timer_hw_limit.sv ***
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: count rises per prescaler tick; on period match it clears at the next tick.
// R2: count and period readable and writable; reset gives count 0, period all ones.
// R3: prescaler divides the timer clock by 1 to 128 in powers of two.
// R4: postscaler gives one output pulse per 1 to 16 period matches.
// R5: count write, control write, reset or external reset clear both scalers.
// R6: a control write never changes the count.
// R7: free-running mode compares each tick; match zeroes count and advances postscaler.
// R8: postscaler equal to postscale field pulses output one timer clock and clears.
// R9: one-shot match clears run enable and stops until software re-enables.
// R10: software keeps postscale at zero in one-shot mode.
// R11: monostable stops at match, keeps run enable, external event restarts it.
// R12: reset source chosen by select register; 5-bit mode picks its effect.
// R13: external edge triggers come at least six timer clocks apart.
// R14: external trigger levels last at least three timer clocks.
// R15: external triggers are ignored during debug freeze.
// R16: gated modes pause on inactive gate; 001 stops when low, 010 runs low.
// R17: free software gate counts while run enable set, stops when cleared.
// R18: edge-reset codes 011 any, 100 rising, 101 falling edge clear the count.
// R19: level-reset codes hold count cleared: 110 while low, 111 while high.
// R20: one-shot software start begins counting as soon as run enable is set.
// R21: one-shot code 001 starts on a rising edge while run enable set.
// R22: one-shot: clock after match clears run enable, stops with count zero.
// R23: monostable: clock after match stops at zero, run enable stays set.
// R24: edge-started modes need a fresh edge after run enable is set again.
// R25: reserved mode codes keep the timer stopped with its count held.
module period_timer_hw_limit (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic timer_clk_en,
    input wire logic debug_freeze,
    input wire logic [period_timer_pkg::SRC_W-1:0] ext_reset_sources,
    input wire period_timer_pkg::reg_req_s reg_req,
    output logic [period_timer_pkg::DATA_W-1:0] rdata,
    output logic period_pulse_out
);

    period_timer_pkg::timer_state_s q;
    period_timer_pkg::timer_state_s next_q;

    // ==========================================
    // combinational next state
    // ==========================================
    always_comb begin
        logic ext_reset_signal;
        logic ers_lvl;
        logic rise;
        logic fall;
        logic any_edge;
        logic [1:0] mclass;
        logic [2:0] low;
        logic gate;
        logic hw_reset;
        logic start;
        logic reserved;
        logic oneshot_like;
        logic mono_like;
        logic run_active;
        logic inc;
        logic clr_scalers;
        logic [period_timer_pkg::PRESC_CNT_W-1:0] presc_last;

        next_q = q;
        ext_reset_signal = 1'b0;
        ers_lvl = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        any_edge = 1'b0;
        gate = 1'b1;
        hw_reset = 1'b0;
        start = 1'b0;
        reserved = 1'b0;
        oneshot_like = 1'b0;
        mono_like = 1'b0;
        run_active = 1'b0;
        inc = 1'b0;
        clr_scalers = 1'b0;
        presc_last = '0;
        mclass = q.mode[period_timer_pkg::MODE_CLASS_LSB +: 2];
        low = q.mode[2:0];

        // source selection sits after the second sync stage only
        next_q.sync1 = ext_reset_sources;
        next_q.sync2 = q.sync1;
        ext_reset_signal = q.sync2[q.src_sel]; // R12
        // freeze holds the last seen level so no edge or level change is seen
        ers_lvl = debug_freeze ? q.ers_prev : ext_reset_signal; // R15
        rise = ers_lvl & ~q.ers_prev;
        fall = ~ers_lvl & q.ers_prev;
        any_edge = rise | fall;
        next_q.ers_prev = ers_lvl;

        // ==========================================
        // mode decode
        // ==========================================
        unique case (mclass)
            period_timer_pkg::CLASS_FREE: begin
                unique case (low)
                    period_timer_pkg::LOW_SW: gate = 1'b1; // R17
                    period_timer_pkg::LOW_1: gate = ers_lvl; // R16
                    period_timer_pkg::LOW_2: gate = ~ers_lvl; // R16
                    period_timer_pkg::LOW_3: hw_reset = any_edge; // R18
                    period_timer_pkg::LOW_4: hw_reset = rise; // R18
                    period_timer_pkg::LOW_5: hw_reset = fall; // R18
                    period_timer_pkg::LOW_6: hw_reset = ~ers_lvl; // R19
                    period_timer_pkg::LOW_7: hw_reset = ers_lvl; // R19
                endcase
            end
            period_timer_pkg::CLASS_ONESHOT: begin
                oneshot_like = 1'b1;
                unique case (low)
                    period_timer_pkg::LOW_SW: start = 1'b1; // R20
                    period_timer_pkg::LOW_1: start = rise; // R21
                    period_timer_pkg::LOW_2: start = fall;
                    period_timer_pkg::LOW_3: start = any_edge;
                    period_timer_pkg::LOW_4: begin
                        start = rise;
                        hw_reset = rise;
                    end
                    period_timer_pkg::LOW_5: begin
                        start = fall;
                        hw_reset = fall;
                    end
                    period_timer_pkg::LOW_6: begin
                        start = rise;
                        hw_reset = ~ers_lvl;
                    end
                    period_timer_pkg::LOW_7: begin
                        start = fall;
                        hw_reset = ers_lvl;
                    end
                endcase
            end
            period_timer_pkg::CLASS_MONO: begin
                unique case (low)
                    period_timer_pkg::LOW_1: begin
                        mono_like = 1'b1;
                        start = rise;
                    end
                    period_timer_pkg::LOW_2: begin
                        mono_like = 1'b1;
                        start = fall;
                    end
                    period_timer_pkg::LOW_3: begin
                        mono_like = 1'b1;
                        start = any_edge;
                    end
                    period_timer_pkg::LOW_6: begin
                        oneshot_like = 1'b1;
                        start = ers_lvl;
                        hw_reset = ~ers_lvl;
                    end
                    period_timer_pkg::LOW_7: begin
                        oneshot_like = 1'b1;
                        start = ~ers_lvl;
                        hw_reset = ers_lvl;
                    end
                    default: reserved = 1'b1; // R25
                endcase
            end
            default: reserved = 1'b1; // R25
        endcase

        // ==========================================
        // start and stop sequencing
        // ==========================================
        if (reserved) begin
            next_q.state = q.state; // R25
            hw_reset = 1'b0;
        end else if (mclass == period_timer_pkg::CLASS_FREE) begin
            next_q.state = period_timer_pkg::ST_IDLE;
            run_active = q.run_enable_bit & gate; // R16 R17
        end else begin
            run_active = (q.state == period_timer_pkg::ST_RUN);
            unique case (q.state)
                period_timer_pkg::ST_IDLE: begin
                    // start is sampled only while enabled, so an edge seen
                    // while disabled is lost and a fresh one is needed
                    if (q.run_enable_bit && start) begin // R24
                        next_q.state = period_timer_pkg::ST_RUN;
                        clr_scalers = 1'b1;
                    end
                end
                period_timer_pkg::ST_RUN: begin
                    if (!q.run_enable_bit) begin
                        next_q.state = period_timer_pkg::ST_IDLE;
                    end
                end
                period_timer_pkg::ST_STOP: begin
                    if (!q.run_enable_bit) begin
                        next_q.state = period_timer_pkg::ST_IDLE;
                    end else if (start) begin
                        next_q.state = period_timer_pkg::ST_RUN; // R11
                        clr_scalers = 1'b1;
                    end
                end
            endcase
        end

        // ==========================================
        // prescaler, count and postscaler
        // ==========================================
        presc_last = period_timer_pkg::PRESC_CNT_W'((8'h01 << q.presc_sel) - 8'h01); // R3
        if (timer_clk_en) begin
            next_q.pulse = 1'b0; // R8
        end
        if (run_active && timer_clk_en) begin
            if (q.presc_cnt >= presc_last) begin
                next_q.presc_cnt = '0;
                inc = 1'b1;
            end else begin
                next_q.presc_cnt = q.presc_cnt + 1'b1;
            end
        end
        if (inc) begin
            if (q.count == q.period) begin // R1 R7
                next_q.count = '0;
                if (q.post_cnt == q.postscale_select) begin // R4 R8
                    next_q.post_cnt = '0;
                    next_q.pulse = 1'b1;
                end else begin
                    next_q.post_cnt = q.post_cnt + 1'b1;
                end
                if (oneshot_like) begin
                    next_q.run_enable_bit = 1'b0; // R9 R22
                    next_q.state = period_timer_pkg::ST_IDLE;
                end else if (mono_like) begin
                    next_q.state = period_timer_pkg::ST_STOP; // R23
                end
            end else begin
                next_q.count = q.count + 1'b1; // R1
            end
        end

        // level modes hold the count at zero for as long as the level lasts
        if (hw_reset) begin
            next_q.count = '0; // R18 R19
            clr_scalers = 1'b1; // R5
        end

        // ==========================================
        // register writes win over hardware updates
        // ==========================================
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                period_timer_pkg::OFS_COUNT: begin
                    next_q.count = reg_req.wdata; // R2
                    clr_scalers = 1'b1; // R5
                end
                period_timer_pkg::OFS_PERIOD: next_q.period = reg_req.wdata; // R2
                period_timer_pkg::OFS_CONTROL: begin
                    next_q.run_enable_bit = reg_req.wdata[period_timer_pkg::CTRL_RUN_BIT];
                    next_q.presc_sel = reg_req.wdata[period_timer_pkg::CTRL_PRESC_LSB +:
                        period_timer_pkg::PRESC_SEL_W];
                    next_q.postscale_select = reg_req.wdata[period_timer_pkg::CTRL_POST_LSB +:
                        period_timer_pkg::POST_W];
                    next_q.count = q.count; // R6
                    clr_scalers = 1'b1; // R5
                end
                period_timer_pkg::OFS_HW_LIMIT: next_q.mode = reg_req.wdata[period_timer_pkg::MODE_W-1:0];
                period_timer_pkg::OFS_RESET_SRC:
                    next_q.src_sel = reg_req.wdata[period_timer_pkg::SRC_SEL_W-1:0]; // R12
                default: ;
            endcase
        end
        if (clr_scalers) begin
            next_q.presc_cnt = '0; // R5
            next_q.post_cnt = '0; // R5
        end

        // read data stand for one cycle only, unmapped reads give zero
        next_q.rdata = period_timer_pkg::READ_IDLE;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                period_timer_pkg::OFS_COUNT: next_q.rdata = q.count; // R2
                period_timer_pkg::OFS_PERIOD: next_q.rdata = q.period; // R2
                period_timer_pkg::OFS_CONTROL:
                    next_q.rdata = {q.run_enable_bit, q.presc_sel, q.postscale_select};
                period_timer_pkg::OFS_HW_LIMIT: next_q.rdata = {3'h0, q.mode};
                period_timer_pkg::OFS_RESET_SRC: next_q.rdata = {5'h00, q.src_sel};
                default: next_q.rdata = period_timer_pkg::READ_IDLE;
            endcase
        end
    end

    // ==========================================
    // state register
    // ==========================================
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= period_timer_pkg::TIMER_STATE_RESET; // R2 R5
        end else begin
            q <= next_q;
        end
    end

    assign rdata = q.rdata;
    assign period_pulse_out = q.pulse;

endmodule

`default_nettype wire

// *** tb/ext_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far side: on-chip peripherals feeding the external reset inputs
// ==========================================
module ext_source_model #(
    parameter int MIN_GAP = 12
) (
    input wire logic sys_clk,
    input wire logic [2:0] sel,
    input wire logic level,
    output wire logic [7:0] srcs
);
    int gap = 0;
    logic cur = 1'b0;
    logic [7:0] drive = 8'h00;
    wire logic take = (level != cur) && (gap >= MIN_GAP);
    // gap counts sys clocks; two per timer clock at the slowest tick rate used
    always @(posedge sys_clk) begin
        gap <= take ? 0 : gap + 1;
        if (take) begin
            cur <= level;
        end
        // unselected sources toggle so a wrong select shows up at once
        for (int i = 0; i < 8; i++) begin
            drive[i] <= (i == sel) ? (take ? level : cur) : ~drive[i];
        end
    end
    assign srcs = drive;
endmodule
`default_nettype wire

// *** tb/period_timer_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module period_timer_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic timer_clk_en,
    input wire period_timer_pkg::reg_req_s reg_req,
    input wire logic [period_timer_pkg::DATA_W-1:0] rdata,
    input wire logic period_pulse_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // ==========================================
    // register port
    // ==========================================
    chk_reset_clear: assert property ($fell(srst) |-> rdata == 8'h00 && !period_pulse_out)
        else $error("outputs not cleared by reset");
    chk_read_idle: assert property (!reg_req.rd |=> rdata == 8'h00)
        else $error("read data outside read slot");
    chk_unmapped_read: assert property (reg_req.rd && reg_req.addr > 3'h4 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_period_back: assert property (reg_req.wr && reg_req.addr == 3'h1
        ##1 reg_req.rd && reg_req.addr == 3'h1 |=> rdata == $past(reg_req.wdata, 2))
        else $error("period readback wrong");
    chk_count_back: assert property (reg_req.wr && reg_req.addr == 3'h0
        ##1 reg_req.rd && reg_req.addr == 3'h0 |=> rdata == $past(reg_req.wdata, 2))
        else $error("count readback wrong");
    chk_mode_back: assert property (reg_req.wr && reg_req.addr == 3'h3
        ##1 reg_req.rd && reg_req.addr == 3'h3 |=> rdata[4:0] == $past(reg_req.wdata[4:0], 2))
        else $error("mode readback wrong");
    chk_ctrl_back: assert property (reg_req.wr && reg_req.addr == 3'h2 && !reg_req.wdata[7]
        ##1 reg_req.rd && reg_req.addr == 3'h2 |=> rdata == $past(reg_req.wdata, 2))
        else $error("control readback wrong");
    // ==========================================
    // period pulse
    // ==========================================
    chk_pulse_hold: assert property (period_pulse_out && !timer_clk_en && !reg_req.wr |=> period_pulse_out)
        else $error("pulse shorter than a timer clock");
    chk_pulse_quiet: assert property (!period_pulse_out && !timer_clk_en |=> !period_pulse_out)
        else $error("pulse rose without a tick");
endmodule
bind period_timer_hw_limit period_timer_checker u_period_timer_checker (.sys_clk(sys_clk), .srst(srst),
    .timer_clk_en(timer_clk_en), .reg_req(reg_req), .rdata(rdata), .period_pulse_out(period_pulse_out));
`default_nettype wire

// *** tb/test_period_timer_hw_limit.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_period_timer_hw_limit;
    localparam logic [2:0] SRC = 3'h5;
    logic sys_clk, srst, debug_freeze, lvl, pulse;
    logic timer_clk_en = 1'b1;
    logic pulse_d = 1'b0;
    logic [period_timer_pkg::SRC_W-1:0] srcs;
    period_timer_pkg::reg_req_s req;
    logic [period_timer_pkg::DATA_W-1:0] rdata, v, w;
    int err_count, n_tests, en_div, p0, c, per, ps, post;
    int phase = 0;
    int pcnt = 0;
    logic [31:0] lfsr;

    period_timer_hw_limit u_period_timer_hw_limit (.sys_clk(sys_clk), .srst(srst), .timer_clk_en(timer_clk_en),
        .debug_freeze(debug_freeze), .ext_reset_sources(srcs), .reg_req(req), .rdata(rdata), .period_pulse_out(pulse));
    ext_source_model u_ext_source_model (.sys_clk(sys_clk), .sel(SRC), .level(lvl), .srcs(srcs));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        phase <= phase + 1;
        timer_clk_en <= ((phase + 1) % en_div) == 0;
        pulse_d <= pulse;
        if (pulse === 1'b1 && pulse_d === 1'b0) pcnt <= pcnt + 1;
    end

    // ==========================================
    // helpers
    // ==========================================
    function automatic logic [31:0] step(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // bus tasks are entered just after a rising edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req <= '0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req <= '0;
        @(posedge sys_clk);
        d = rdata;
    endtask

    task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req <= '0;
        @(posedge sys_clk);
        q = rdata;
    endtask

    task automatic wait_lvl(input logic l, inout int cyc);
        int k;
        for (k = 0; k < 5000 && pulse !== l; k++) begin
            @(posedge sys_clk);
            cyc++;
        end
        if (pulse !== l) begin
            err_count++;
            results();
        end
    endtask

    // one run from a stopped timer: pulses before and after one source edge
    task automatic trig(input logic [4:0] m, input int pre, input int post_n, input logic [7:0] ctrl);
        wr(3'h2, 8'h00);
        wr(3'h1, 8'h03);
        wr(3'h0, 8'h00);
        wr(3'h3, {3'h0, m});
        p0 = pcnt;
        wr(3'h2, 8'h80);
        repeat (20) @(posedge sys_clk);
        check(pcnt - p0, pre);
        lvl <= ~lvl;
        repeat (30) @(posedge sys_clk);
        check(pcnt - p0, pre + post_n);
        rd(3'h2, v);
        check(v, ctrl);
    endtask

    // ==========================================
    // main sequence
    // ==========================================
    initial begin
        srst = 1'b1;
        req = '0;
        debug_freeze = 1'b0;
        lvl = 1'b0;
        en_div = 1;
        err_count = 0;
        n_tests = 0;
        lfsr = 32'h52a8_e712;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        rd(3'h0, v);
        check(v, 8'h00);
        rd(3'h1, v);
        check(v, 8'hff);
        rd(3'h6, v);
        check(v, 8'h00);
        wr_rd(3'h1, lfsr[7:0], v);
        check(v, lfsr[7:0]);
        wr_rd(3'h3, 8'h00, v);
        check(v, 8'h00);
        wr_rd(3'h0, 8'h5a, v);
        check(v, 8'h5a);
        wr(3'h7, 8'h33);
        wr_rd(3'h2, 8'h35, v);
        check(v, 8'h35);
        rd(3'h0, v);
        check(v, 8'h5a);
        wr(3'h4, {5'h00, SRC});
        // free running: random and boundary scaler settings, tick every one or two clocks
        for (int i = 0; i < 8; i++) begin
            lfsr = step(lfsr);
            per = 1 + lfsr[2:0] % 5;
            ps = lfsr[5:4];
            post = lfsr[11:8] % 4;
            en_div = 1 + i % 2;
            if (i == 6) begin
                per = 1;
                ps = 7;
                post = 0;
            end
            if (i == 7) begin
                per = 1;
                ps = 0;
                post = 15;
            end
            wr(3'h2, 8'h00);
            wr(3'h1, per[7:0]);
            wr(3'h0, 8'h00);
            wr(3'h2, 8'h80 | (ps[7:0] << 4) | post[7:0]);
            c = 0;
            wait_lvl(1'b1, c);
            c = 0;
            wait_lvl(1'b0, c);
            check(c, en_div);
            wait_lvl(1'b1, c);
            check(c, en_div * (per + 1) * (1 << ps) * (post + 1));
        end
        en_div = 1;
        trig(5'h08, 1, 0, 8'h00);
        trig(5'h12, 0, 1, 8'h80);
        trig(5'h09, 0, 1, 8'h00);
        trig(5'h13, 0, 1, 8'h80);
        lvl <= ~lvl;
        repeat (30) @(posedge sys_clk);
        check(pcnt - p0, 2);
        trig(5'h18, 0, 0, 8'h80);
        // free running with source effects, long period
        wr(3'h2, 8'h00);
        wr(3'h1, 8'hff);
        wr(3'h3, 8'h07);
        wr(3'h0, 8'h00);
        wr(3'h2, 8'h80);
        lvl <= 1'b1;
        repeat (20) @(posedge sys_clk);
        rd(3'h0, v);
        check(v, 8'h00);
        lvl <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rd(3'h0, v);
        check(v > 8'h08, 1'b1);
        wr(3'h3, 8'h01);
        rd(3'h0, v);
        repeat (10) @(posedge sys_clk);
        rd(3'h0, w);
        check(w, v);
        wr(3'h3, 8'h02);
        rd(3'h0, v);
        rd(3'h0, w);
        check(w != v, 1'b1);
        wr(3'h3, 8'h04);
        wr(3'h0, 8'h80);
        debug_freeze <= 1'b1;
        lvl <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(3'h0, v);
        check(v >= 8'h80, 1'b1);
        lvl <= 1'b0;
        repeat (14) @(posedge sys_clk);
        debug_freeze <= 1'b0;
        lvl <= 1'b1;
        // the partner holds this edge back to keep its spacing, then two sync stages
        repeat (12) @(posedge sys_clk);
        rd(3'h0, v);
        check(v < 8'h10, 1'b1);
        // mid-run reset brings period and count back to their reset values
        wr(3'h1, 8'h3c);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        rd(3'h1, v);
        check(v, 8'hff);
        rd(3'h0, v);
        check(v, 8'h00);
        results();
    end
endmodule
`default_nettype wire
